// *** verilog/afe_cfg_defs.svh ***
`ifndef AFE_CFG_DEFS_SVH
`define AFE_CFG_DEFS_SVH

// byte addresses on the serial register port
`define ADDR_INPUT_SEL      7'h03
`define ADDR_FEEDBACK_GAIN  7'h06
`define ADDR_SPEED_MODE     7'h09
`define ADDR_REGULATOR      7'h0b
`define ADDR_REF_LIMITS     7'h0c

// values after reset
`define RST_INPUT_SEL       8'h00
`define RST_FEEDBACK_GAIN   8'h00
`define RST_SPEED_MODE      8'h00
`define RST_REGULATOR       8'h0d
`define RST_REF_LIMITS      8'h00

// writable bits; all other positions are fixed zero
`define MASK_INPUT_SEL      8'hff
`define MASK_FEEDBACK_GAIN  8'h1f
`define MASK_SPEED_MODE     8'h03
`define MASK_REGULATOR      8'h0f
`define MASK_REF_LIMITS     8'h0f

// field positions (lsb of each field)
`define POS_INV_SEL         6
`define POS_NONINV_SEL      4
`define POS_GAIN_CODE       0
`define POS_SPEED_SEL       0
`define POS_REG_CODE        0
`define POS_UPPER_SEL       2
`define POS_LOWER_SEL       0

// decode constants
`define GAIN_CODE_MAX       5'h11
`define GAIN_CODES_PER_X2   5'h03
`define GAIN_BASE_KOHM      10'h014
`define REG_CODE_MAX        4'hd
`define REG_BASE_MV         12'h7d0
`define REG_STEP_MV         12'h064

// serial frame
`define FRAME_CMD_LAST_BIT  4'h7
`define FRAME_LAST_BIT      4'hf

`endif

// *** verilog/afe_cfg_pkg.sv ***
package afe_cfg_pkg;

    typedef enum logic [1:0] {
        SRC_PIN0 = 2'b00,
        SRC_PIN1 = 2'b01,
        SRC_REF  = 2'b10,
        SRC_OPEN = 2'b11
    } input_src_type;

    typedef enum logic [1:0] {
        SPEED_HIGH = 2'b00,
        SPEED_MID2 = 2'b01,
        SPEED_MID1 = 2'b10,
        SPEED_LOW  = 2'b11
    } speed_mode_type;

    // one-hot switch enables; all zero leaves the input open
    typedef struct packed {
        logic pin_zero;
        logic pin_one;
        logic ref_path;
    } input_switch_type;

    // limits in tenths of the analog supply; zero means analog ground
    typedef struct packed {
        logic [3:0] upper_tenths;
        logic [3:0] lower_tenths;
    } ref_limit_type;

    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] data;
    } reg_write_type;

endpackage

// *** verilog/spi_reg_port.sv ***
`timescale 1ns/1ps
`include "afe_cfg_defs.svh"

// mode 0 serial slave: byte one is {write, addr[6:0]}, byte two is data.
// pins are synchronous to core_clk, so sclk must be well below core_clk / 2.
module spi_reg_port (
    input  wire logic                      core_clk,
    input  wire logic                      nrst,
    input  wire logic                      spi_sclk,
    input  wire logic                      spi_cs_n,
    input  wire logic                      spi_mosi,
    input  wire logic [7:0]                rd_data,
    output logic                           spi_miso,
    output logic [6:0]                     addr,
    output afe_cfg_pkg::reg_write_type     wr_req
);
    logic       sclk_q;
    logic [3:0] bit_cnt_q;
    logic [6:0] shift_in_q;
    logic       is_write_q;
    logic [6:0] addr_q;
    logic [7:0] shift_out_q;
    logic       miso_q;
    afe_cfg_pkg::reg_write_type wr_q;

    wire rise     = spi_sclk & ~sclk_q & ~spi_cs_n;
    wire fall     = ~spi_sclk & sclk_q & ~spi_cs_n;
    wire cmd_done = rise && bit_cnt_q == `FRAME_CMD_LAST_BIT;
    wire dat_done = rise && bit_cnt_q == `FRAME_LAST_BIT;
    wire rd_load  = fall && bit_cnt_q == 4'h8 && !is_write_q;
    wire rd_shift = fall && bit_cnt_q > 4'h8 && !is_write_q;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sclk_q      <= 1'b0;
            bit_cnt_q   <= 4'h0;
            shift_in_q  <= 7'h00;
            is_write_q  <= 1'b0;
            addr_q      <= 7'h00;
            shift_out_q <= 8'h00;
            miso_q      <= 1'b0;
            wr_q        <= '0;
        end else begin
            sclk_q <= spi_sclk;
            wr_q   <= '0;
            if (spi_cs_n) begin
                // a frame cut short never writes
                bit_cnt_q <= 4'h0;
                miso_q    <= 1'b0;
            end else if (rise) begin
                shift_in_q <= {shift_in_q[5:0], spi_mosi};
                bit_cnt_q  <= bit_cnt_q + 4'h1;
            end
            if (cmd_done) begin
                is_write_q <= shift_in_q[6];
                addr_q     <= {shift_in_q[5:0], spi_mosi};
            end
            if (dat_done && is_write_q) begin
                wr_q.wr   <= 1'b1;
                wr_q.addr <= addr_q;
                wr_q.data <= {shift_in_q, spi_mosi};
            end
            if (rd_load) begin
                miso_q      <= rd_data[7];
                shift_out_q <= {rd_data[6:0], 1'b0};
            end else if (rd_shift) begin
                miso_q      <= shift_out_q[7];
                shift_out_q <= {shift_out_q[6:0], 1'b0};
            end
        end
    end

    assign spi_miso = miso_q;
    assign addr     = addr_q;
    assign wr_req   = wr_q;
endmodule

// *** verilog/afe_cfg_regs.sv ***
`timescale 1ns/1ps
`include "afe_cfg_defs.svh"

module afe_cfg_regs #(
    parameter int NUM_CONVERTERS = 4
) (
    input  wire logic                                core_clk,
    input  wire logic                                nrst,
    input  wire logic                                spi_sclk,
    input  wire logic                                spi_cs_n,
    input  wire logic                                spi_mosi,
    output logic                                     spi_miso,
    output afe_cfg_pkg::input_switch_type            inv_switch,
    output afe_cfg_pkg::input_switch_type            noninv_switch,
    output logic [3:0]                               aux_select,
    output logic [4:0]                               gain_code,
    output logic [2:0]                               gain_doublings,
    output logic [9:0]                               feedback_kohm,
    output logic                                     gain_code_ok,
    output afe_cfg_pkg::speed_mode_type              speed_mode,
    output logic [3:0]                               reg_code,
    output logic [11:0]                              reg_millivolts,
    output logic                                     reg_code_ok,
    output afe_cfg_pkg::ref_limit_type [NUM_CONVERTERS-1:0] conv_ref
);
    logic [7:0] input_sel_q;
    logic [7:0] gain_q;
    logic [7:0] speed_q;
    logic [7:0] regulator_q;
    logic [7:0] limits_q;

    logic [6:0]                 rd_addr;
    logic [7:0]                 rd_data;
    afe_cfg_pkg::reg_write_type wr_req;

    spi_reg_port u_port (
        .core_clk (core_clk),
        .nrst     (nrst),
        .spi_sclk (spi_sclk),
        .spi_cs_n (spi_cs_n),
        .spi_mosi (spi_mosi),
        .rd_data  (rd_data),
        .spi_miso (spi_miso),
        .addr     (rd_addr),
        .wr_req   (wr_req)
    );

    // write decode
    wire wr_input_sel = wr_req.wr && wr_req.addr == `ADDR_INPUT_SEL;
    wire wr_gain      = wr_req.wr && wr_req.addr == `ADDR_FEEDBACK_GAIN;
    wire wr_speed     = wr_req.wr && wr_req.addr == `ADDR_SPEED_MODE;
    wire wr_regulator = wr_req.wr && wr_req.addr == `ADDR_REGULATOR;
    wire wr_limits    = wr_req.wr && wr_req.addr == `ADDR_REF_LIMITS;

    // read decode; unmapped addresses read 00h
    wire rd_input_sel = rd_addr == `ADDR_INPUT_SEL;
    wire rd_gain      = rd_addr == `ADDR_FEEDBACK_GAIN;
    wire rd_speed     = rd_addr == `ADDR_SPEED_MODE;
    wire rd_regulator = rd_addr == `ADDR_REGULATOR;
    wire rd_limits    = rd_addr == `ADDR_REF_LIMITS;

    assign rd_data = ({8{rd_input_sel}} & input_sel_q)
                   | ({8{rd_gain}}      & gain_q)
                   | ({8{rd_speed}}     & speed_q)
                   | ({8{rd_regulator}} & regulator_q)
                   | ({8{rd_limits}}    & limits_q);

    // prohibited codes are stored as written; the ok flags report them
    // one short block per register keeps each write path easy to follow
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            input_sel_q <= `RST_INPUT_SEL;
        end else if (wr_input_sel) begin
            input_sel_q <= wr_req.data & `MASK_INPUT_SEL;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            gain_q <= `RST_FEEDBACK_GAIN;
        end else if (wr_gain) begin
            gain_q <= wr_req.data & `MASK_FEEDBACK_GAIN;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            speed_q <= `RST_SPEED_MODE;
        end else if (wr_speed) begin
            speed_q <= wr_req.data & `MASK_SPEED_MODE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            regulator_q <= `RST_REGULATOR;
        end else if (wr_regulator) begin
            regulator_q <= wr_req.data & `MASK_REGULATOR;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            limits_q <= `RST_REF_LIMITS;
        end else if (wr_limits) begin
            limits_q <= wr_req.data & `MASK_REF_LIMITS;
        end
    end

    // field extraction
    wire [1:0] inv_sel    = input_sel_q[`POS_INV_SEL +: 2];
    wire [1:0] noninv_sel = input_sel_q[`POS_NONINV_SEL +: 2];
    wire [4:0] gain_fld   = gain_q[`POS_GAIN_CODE +: 5];
    wire [1:0] speed_fld  = speed_q[`POS_SPEED_SEL +: 2];
    wire [3:0] reg_fld    = regulator_q[`POS_REG_CODE +: 4];
    wire [1:0] upper_fld  = limits_q[`POS_UPPER_SEL +: 2];
    wire [1:0] lower_fld  = limits_q[`POS_LOWER_SEL +: 2];

    // input multiplexer decode
    afe_cfg_pkg::input_switch_type inv_d;
    afe_cfg_pkg::input_switch_type noninv_d;
    assign inv_d.pin_zero    = inv_sel == afe_cfg_pkg::SRC_PIN0;
    assign inv_d.pin_one     = inv_sel == afe_cfg_pkg::SRC_PIN1;
    assign inv_d.ref_path    = inv_sel == afe_cfg_pkg::SRC_REF;
    assign noninv_d.pin_zero = noninv_sel == afe_cfg_pkg::SRC_PIN0;
    assign noninv_d.pin_one  = noninv_sel == afe_cfg_pkg::SRC_PIN1;
    assign noninv_d.ref_path = noninv_sel == afe_cfg_pkg::SRC_REF;

    // feedback: codes between the doubling points keep the lower value
    wire [4:0] gain_quot = gain_fld / `GAIN_CODES_PER_X2;
    wire [2:0] dbl_d     = gain_quot[2:0];
    wire [9:0] kohm_d    = `GAIN_BASE_KOHM << dbl_d;
    wire       gain_ok_d = gain_fld <= `GAIN_CODE_MAX;

    // regulator output in millivolts
    wire [11:0] mv_d     = 12'(`REG_BASE_MV + {8'h00, reg_fld} * `REG_STEP_MV);
    wire        reg_ok_d = reg_fld <= `REG_CODE_MAX;

    // reference limits in tenths of the supply
    afe_cfg_pkg::ref_limit_type limit_d;
    assign limit_d.upper_tenths = (upper_fld == 2'b01) ? 4'h4 :
                                  (upper_fld == 2'b10) ? 4'h3 : 4'h5;
    assign limit_d.lower_tenths = (lower_fld == 2'b01) ? 4'h1 :
                                  (lower_fld == 2'b10) ? 4'h2 : 4'h0;

    // decoded outputs are registered, one cycle behind the stored value
    afe_cfg_pkg::input_switch_type inv_q;
    afe_cfg_pkg::input_switch_type noninv_q;
    afe_cfg_pkg::speed_mode_type   speed_mode_q;
    afe_cfg_pkg::ref_limit_type    limit_q;
    logic [3:0]  aux_q;
    logic [4:0]  gain_code_q;
    logic [2:0]  dbl_q;
    logic [9:0]  kohm_q;
    logic        gain_ok_q;
    logic [3:0]  reg_code_q;
    logic [11:0] mv_q;
    logic        reg_ok_q;

    // reset values equal the decode of the register defaults, so release shows no step
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            inv_q        <= 3'b100;
            noninv_q     <= 3'b100;
            aux_q        <= 4'h0;
            speed_mode_q <= afe_cfg_pkg::SPEED_HIGH;
            limit_q      <= 8'h50;
        end else begin
            inv_q        <= inv_d;
            noninv_q     <= noninv_d;
            aux_q        <= input_sel_q[3:0];
            speed_mode_q <= afe_cfg_pkg::speed_mode_type'(speed_fld);
            limit_q      <= limit_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            gain_code_q  <= 5'h00;
            dbl_q        <= 3'h0;
            kohm_q       <= `GAIN_BASE_KOHM;
            gain_ok_q    <= 1'b1;
            reg_code_q   <= 4'hd;
            mv_q         <= 12'hce4;
            reg_ok_q     <= 1'b1;
        end else begin
            gain_code_q  <= gain_fld;
            dbl_q        <= dbl_d;
            kohm_q       <= kohm_d;
            gain_ok_q    <= gain_ok_d;
            reg_code_q   <= reg_fld;
            mv_q         <= mv_d;
            reg_ok_q     <= reg_ok_d;
        end
    end

    assign inv_switch     = inv_q;
    assign noninv_switch  = noninv_q;
    assign aux_select     = aux_q;
    assign gain_code      = gain_code_q;
    assign gain_doublings = dbl_q;
    assign feedback_kohm  = kohm_q;
    assign gain_code_ok   = gain_ok_q;
    assign speed_mode     = speed_mode_q;
    assign reg_code       = reg_code_q;
    assign reg_millivolts = mv_q;
    assign reg_code_ok    = reg_ok_q;

    // one shared selection fans out to every converter
    for (genvar i = 0; i < NUM_CONVERTERS; i++) begin : g_conv
        assign conv_ref[i] = limit_q;
    end
endmodule

// *** dv/spi_host_model.sv ***
`timescale 1ns/1ps

// host side of the register port: mode 0, sclk idles low, one transfer per frame
module spi_host_model (
    input  wire logic core_clk,
    input  wire logic spi_miso,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // n below 16 ends the frame early, which must not write
    task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
                        input int n, output logic [7:0] q);
        logic [15:0] f;
        int          i;
        f = {wr, a, d};
        q = 8'h00;
        @(posedge core_clk);
        spi_cs_n <= 1'b0;
        for (i = 15; i > 15 - n; i--) begin
            spi_mosi <= f[i];
            repeat (4) @(posedge core_clk);
            spi_sclk <= 1'b1;
            if (i < 8) q[i] = spi_miso;
            repeat (4) @(posedge core_clk);
            spi_sclk <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        spi_cs_n <= 1'b1;
        // released data line flips so a stale level is never mistaken for data
        spi_mosi <= ~spi_mosi;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

// *** dv/afe_cfg_regs_monitor.sv ***
`timescale 1ns/1ps

module afe_cfg_regs_monitor #(
    parameter int NUM_CONVERTERS = 4
) (
    input wire logic                                   core_clk,
    input wire logic                                   nrst,
    input wire logic                                   spi_sclk,
    input wire logic                                   spi_cs_n,
    input wire logic                                   spi_mosi,
    input wire logic                                   spi_miso,
    input wire afe_cfg_pkg::input_switch_type          inv_switch,
    input wire afe_cfg_pkg::input_switch_type          noninv_switch,
    input wire logic [3:0]                             aux_select,
    input wire logic [4:0]                             gain_code,
    input wire logic [2:0]                             gain_doublings,
    input wire logic [9:0]                             feedback_kohm,
    input wire logic                                   gain_code_ok,
    input wire afe_cfg_pkg::speed_mode_type            speed_mode,
    input wire logic [3:0]                             reg_code,
    input wire logic [11:0]                            reg_millivolts,
    input wire logic                                   reg_code_ok,
    input wire afe_cfg_pkg::ref_limit_type [NUM_CONVERTERS-1:0] conv_ref
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    chk_gain_kohm: assert property (
        gain_code_ok |-> feedback_kohm == (10'h014 << gain_doublings))
        else $error("feedback resistance does not follow doublings");
    chk_gain_div: assert property (gain_doublings == 3'(gain_code / 5'h03))
        else $error("doublings not gain code over three");
    chk_gain_ok: assert property (gain_code_ok == (gain_code <= 5'h11))
        else $error("gain code flag wrong");
    chk_reg_mv: assert property (
        reg_code_ok |-> reg_millivolts == 12'h7d0 + 12'h064 * 12'(reg_code))
        else $error("regulator voltage wrong");
    chk_reg_ok: assert property (reg_code_ok == (reg_code <= 4'hd))
        else $error("regulator code flag wrong");
    chk_switch_onehot: assert property ($onehot0(inv_switch) && $onehot0(noninv_switch))
        else $error("input switches not one-hot");
    chk_ref_shared: assert property (conv_ref == {NUM_CONVERTERS{conv_ref[0]}})
        else $error("converter limits differ");
    chk_ref_range: assert property (
        conv_ref[0].upper_tenths inside {4'h3, 4'h4, 4'h5}
            && conv_ref[0].lower_tenths <= 4'h2)
        else $error("reference limit out of range");
    chk_reset_vals: assert property (disable iff (1'b0)
        !nrst |=> reg_code == 4'hd && gain_code == 5'h00 && aux_select == 4'h0
            && spi_miso == 1'b0)
        else $error("reset values wrong");
    chk_miso_idle: assert property (spi_cs_n && $past(spi_cs_n) |-> spi_miso == 1'b0)
        else $error("read data driven outside frame");
    chk_cfg_quiet: assert property (
        $changed(gain_code) || $changed(reg_code) || $changed(speed_mode)
            || $changed(aux_select) |-> !$past(spi_cs_n, 3))
        else $error("setting changed without a frame");
endmodule

bind afe_cfg_regs afe_cfg_regs_monitor #(.NUM_CONVERTERS(NUM_CONVERTERS)) i_mon (
    .core_clk(core_clk), .nrst(nrst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .inv_switch(inv_switch),
    .noninv_switch(noninv_switch), .aux_select(aux_select), .gain_code(gain_code),
    .gain_doublings(gain_doublings), .feedback_kohm(feedback_kohm),
    .gain_code_ok(gain_code_ok), .speed_mode(speed_mode), .reg_code(reg_code),
    .reg_millivolts(reg_millivolts), .reg_code_ok(reg_code_ok), .conv_ref(conv_ref));

// *** dv/tb.sv ***
`timescale 1ns/1ps
`include "afe_cfg_defs.svh"

module tb;
    logic                                   core_clk;
    logic                                   nrst;
    logic                                   spi_sclk;
    logic                                   spi_cs_n;
    logic                                   spi_mosi;
    logic                                   spi_miso;
    afe_cfg_pkg::input_switch_type          inv_switch;
    afe_cfg_pkg::input_switch_type          noninv_switch;
    logic [3:0]                             aux_select;
    logic [4:0]                             gain_code;
    logic [2:0]                             gain_doublings;
    logic [9:0]                             feedback_kohm;
    logic                                   gain_code_ok;
    afe_cfg_pkg::speed_mode_type            speed_mode;
    logic [3:0]                             reg_code;
    logic [11:0]                            reg_millivolts;
    logic                                   reg_code_ok;
    afe_cfg_pkg::ref_limit_type [3:0]       conv_ref;
    int                                     bad_count = 0;
    int                                     num_checks = 0;
    int                                     seed;
    logic [7:0]                             shadow [5];
    logic [6:0] addr_t [5] = '{`ADDR_INPUT_SEL, `ADDR_FEEDBACK_GAIN, `ADDR_SPEED_MODE,
                               `ADDR_REGULATOR, `ADDR_REF_LIMITS};
    logic [7:0] mask_t [5] = '{`MASK_INPUT_SEL, `MASK_FEEDBACK_GAIN, `MASK_SPEED_MODE,
                               `MASK_REGULATOR, `MASK_REF_LIMITS};
    logic [7:0] rst_t [5]  = '{`RST_INPUT_SEL, `RST_FEEDBACK_GAIN, `RST_SPEED_MODE,
                               `RST_REGULATOR, `RST_REF_LIMITS};

    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    afe_cfg_regs #(.NUM_CONVERTERS(4)) i_dut (
        .core_clk(core_clk), .nrst(nrst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .inv_switch(inv_switch),
        .noninv_switch(noninv_switch), .aux_select(aux_select), .gain_code(gain_code),
        .gain_doublings(gain_doublings), .feedback_kohm(feedback_kohm),
        .gain_code_ok(gain_code_ok), .speed_mode(speed_mode), .reg_code(reg_code),
        .reg_millivolts(reg_millivolts), .reg_code_ok(reg_code_ok), .conv_ref(conv_ref));

    spi_host_model i_host (.core_clk(core_clk), .spi_miso(spi_miso), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));

    function automatic logic [2:0] sw_exp(input logic [1:0] s);
        sw_exp = (s == 2'b00) ? 3'b100 : (s == 2'b01) ? 3'b010 : (s == 2'b10) ? 3'b001 : 3'b000;
    endfunction

    function automatic logic [7:0] ref_exp(input logic [3:0] r);
        ref_exp[7:4] = (r[3:2] == 2'b01) ? 4'h4 : (r[3:2] == 2'b10) ? 4'h3 : 4'h5;
        ref_exp[3:0] = (r[1:0] == 2'b01) ? 4'h1 : (r[1:0] == 2'b10) ? 4'h2 : 4'h0;
    endfunction

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t register read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t output %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wr(input int k, input logic [7:0] d);
        logic [7:0] q;
        i_host.xfer(1'b1, addr_t[k], d, 16, q);
        shadow[k] = d & mask_t[k];
    endtask

    // reads every register back and compares every decoded output with the shadow
    task automatic check_all;
        logic [7:0] q;
        int         i;
        for (i = 0; i < 5; i++) begin
            i_host.xfer(1'b0, addr_t[i], 8'h00, 16, q);
            chk_reg(q, shadow[i]);
        end
        chk_out(12'(inv_switch), 12'(sw_exp(shadow[0][7:6])));
        chk_out(12'(noninv_switch), 12'(sw_exp(shadow[0][5:4])));
        chk_out(12'(aux_select), 12'(shadow[0][3:0]));
        chk_out(12'(feedback_kohm), 12'(10'h014 << (shadow[1][4:0] / 5'h03)));
        chk_out(12'(gain_code), 12'(shadow[1][4:0]));
        chk_out(12'(gain_doublings), 12'(shadow[1][4:0] / 5'h03));
        chk_out(12'(gain_code_ok), 12'(shadow[1][4:0] <= 5'h11));
        chk_out(12'(speed_mode), 12'(shadow[2][1:0]));
        chk_out(reg_millivolts, 12'h7d0 + 12'h064 * 12'(shadow[3][3:0]));
        chk_out(12'(reg_code), 12'(shadow[3][3:0]));
        chk_out(12'(reg_code_ok), 12'(shadow[3][3:0] <= 4'hd));
        for (i = 0; i < 4; i++) begin
            chk_out(12'(conv_ref[i]), 12'(ref_exp(shadow[4][3:0])));
        end
    endtask

    initial begin
        logic [7:0] d;
        logic [7:0] q;
        int         n;
        nrst <= 1'b0;
        seed = 32'h9656;
        shadow = rst_t;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        check_all;
        $display("test reset defaults done");
        wr(1, 8'hf1);
        wr(3, 8'hfd);
        wr(4, 8'hff);
        wr(0, 8'hb4);
        wr(2, 8'hfe);
        check_all;
        wr(1, 8'h0f);
        wr(3, 8'h00);
        wr(0, 8'h6b);
        check_all;
        $display("test corner codes done");
        for (n = 0; n < 15; n++) begin
            d = 8'($random(seed));
            if (n % 5 == 1) d[4:0] = d[4:0] % 5'h12;
            if (n % 5 == 3) d[3:0] = d[3:0] % 4'he;
            wr(n % 5, d);
            check_all;
        end
        $display("test random writes done");
        d = ~shadow[2];
        i_host.xfer(1'b1, addr_t[2], d, 10, q);
        check_all;
        $display("test short frame done");
        i_host.xfer(1'b1, 7'h05, 8'hff, 16, q);
        i_host.xfer(1'b0, 7'h05, 8'h00, 16, q);
        chk_reg(q, 8'h00);
        check_all;
        $display("test unmapped address done");
        nrst <= 1'b0;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        shadow = rst_t;
        check_all;
        $display("test second reset done");
        test_done;
    end

    // about 22 frame groups of some 840 cycles each fit well inside this span
    initial begin
        repeat (60000) @(posedge core_clk);
        bad_count++;
        $display("ERROR %0t watchdog expired", $time);
        test_done;
    end
endmodule
